/* src/csf_pkg.sv */
/*
  Constants and carrier types for the calendar status flags block.
  Assumes a single 125 MHz clock domain with a synchronous active-high reset.
*/
package csf_pkg;

  localparam logic [7:0]  STATUS_OFFSET    = 8'h0C;
  localparam logic [31:0] STATUS_RESET     = 32'h0000_0007;
  localparam logic [31:0] STATUS_WMASK     = 32'h0000_7FA0;

  localparam int BIT_RECAL       = 16;
  localparam int BIT_TAMPER_TWO  = 14;
  localparam int BIT_TAMPER_ONE  = 13;
  localparam int BIT_TS_OVF      = 12;
  localparam int BIT_TS          = 11;
  localparam int BIT_WAKEUP      = 10;
  localparam int BIT_ALARM_B     = 9;
  localparam int BIT_ALARM_A     = 8;
  localparam int BIT_INIT_REQ    = 7;
  localparam int BIT_INIT_ACK    = 6;
  localparam int BIT_SHADOW_SYNC = 5;
  localparam int BIT_CAL_INIT    = 4;
  localparam int BIT_SHIFT_PEND  = 3;
  localparam int BIT_WAKEUP_WP   = 2;
  localparam int BIT_ALARM_B_WP  = 1;
  localparam int BIT_ALARM_A_WP  = 0;

  // Shadow refresh period in kernel cycles, and init entry delay
  localparam logic [1:0] SHADOW_PERIOD  = 2'h2;
  localparam logic [1:0] INIT_ENTRY_CYC = 2'h2;

  typedef enum logic [1:0] {
    CSF_RUN      = 2'b00,
    CSF_ENTERING = 2'b01,
    CSF_INIT     = 2'b10
  } csf_mode_t;

  // Hardware events into the status register, one-cycle pulses
  typedef struct packed {
    logic calib_write;
    logic calib_done;
    logic tamper_two;
    logic tamper_one;
    logic timestamp;
    logic wakeup_zero;
    logic alarm_b_match;
    logic alarm_a_match;
    logic shift_write;
    logic shift_done;
  } csf_events_t;

  // Level conditions from the rest of the clock
  typedef struct packed {
    logic shadow_bypass;
    logic year_nonzero;
    logic wakeup_enable;
    logic alarm_b_enable;
    logic alarm_a_enable;
  } csf_levels_t;

endpackage : csf_pkg

/* src/csf_event_flag.sv */
/*
  One sticky status flag: set by a hardware pulse, cleared by a write of zero.
  Assumes the register port decodes the address and passes the written bit.
*/
`timescale 1ns/10ps
`default_nettype none
module csf_event_flag (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  // Set and clear
  input  wire logic set,
  input  wire logic wr_en,
  input  wire logic wr_bit,
  // Flag
  output logic      flag
);

  typedef struct packed {
    logic flag;
  } csf_flag_state_t;

  csf_flag_state_t st;
  csf_flag_state_t next_st;

  always_comb begin
    next_st = st;
    // Writing one keeps the flag; a set in the clear cycle wins
    if (wr_en && !wr_bit) begin
      next_st.flag = 1'b0;
    end
    if (set) begin
      next_st.flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign flag = st.flag;

  chk_set_wins_clear: assert property (@(posedge clk) disable iff (srst)
    ce && set |=> flag) else $error("flag lost a set event");
  chk_one_keeps_flag: assert property (@(posedge clk) disable iff (srst)
    ce && flag && wr_en && wr_bit |=> flag) else $error("write of one cleared flag");

endmodule : csf_event_flag
`default_nettype wire

/* src/csf_status.sv */
/*
  Status and initialization-control register of the calendar clock.
  Assumes event pulses and levels arrive from logic on the same clock;
  the register port is a one-cycle strobe port with read data a cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
module csf_status (
  // Clock, reset, enable
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                ce,
  // Register port
  input  wire logic [7:0]          addr,
  input  wire logic [31:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic      [31:0]         rdata,
  // Calendar core
  input  wire csf_pkg::csf_events_t ev,
  input  wire csf_pkg::csf_levels_t lv,
  output logic                     init_mode,
  output logic                     shadow_load
);

  typedef struct packed {
    csf_pkg::csf_mode_t mode;
    logic [1:0]         mode_cnt;
    logic [1:0]         shadow_cnt;
    logic               recal;
    logic               init_req;
    logic               shadow_sync;
    logic               cal_init;
    logic               shift_pend;
    logic               wakeup_wp;
    logic               alarm_b_wp;
    logic               alarm_a_wp;
    logic               shadow_load;
    logic               init_mode;
    logic [31:0]        rdata;
  } csf_state_t;

  csf_state_t st;
  csf_state_t next_st;

  logic       hit_wr;
  logic [5:0] fset;
  logic [5:0] fbit;
  logic [5:0] fwdata;
  logic [31:0] status;

  assign hit_wr = wr && (addr == csf_pkg::STATUS_OFFSET);

  // Sticky event flags: tamper two, tamper one, overflow, timestamp, wakeup, alarm B, alarm A
  assign fset[5] = ev.tamper_two;
  assign fset[4] = ev.tamper_one;
  assign fset[3] = ev.timestamp;
  assign fset[2] = ev.wakeup_zero;
  assign fset[1] = ev.alarm_b_match;
  assign fset[0] = ev.alarm_a_match;

  assign fwdata = {wdata[csf_pkg::BIT_TAMPER_TWO], wdata[csf_pkg::BIT_TAMPER_ONE],
                   wdata[csf_pkg::BIT_TS], wdata[csf_pkg::BIT_WAKEUP],
                   wdata[csf_pkg::BIT_ALARM_B], wdata[csf_pkg::BIT_ALARM_A]};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_flag
      csf_event_flag u_flag (
        .clk    (clk),
        .srst   (srst),
        .ce     (ce),
        .set    (fset[gi]),
        .wr_en  (hit_wr),
        .wr_bit (fwdata[gi]),
        .flag   (fbit[gi])
      );
    end
  endgenerate

  logic ts_ovf;
  // Overflow only when a timestamp event hits the timestamp flag while it is already set
  csf_event_flag u_overflow (
    .clk    (clk),
    .srst   (srst),
    .ce     (ce),
    .set    (ev.timestamp && fbit[3]),
    .wr_en  (hit_wr),
    .wr_bit (wdata[csf_pkg::BIT_TS_OVF]),
    .flag   (ts_ovf)
  );

  always_comb begin
    status = '0;
    status[csf_pkg::BIT_RECAL]       = st.recal;
    status[csf_pkg::BIT_TAMPER_TWO]  = fbit[5];
    status[csf_pkg::BIT_TAMPER_ONE]  = fbit[4];
    status[csf_pkg::BIT_TS_OVF]      = ts_ovf;
    status[csf_pkg::BIT_TS]          = fbit[3];
    status[csf_pkg::BIT_WAKEUP]      = fbit[2];
    status[csf_pkg::BIT_ALARM_B]     = fbit[1];
    status[csf_pkg::BIT_ALARM_A]     = fbit[0];
    status[csf_pkg::BIT_INIT_REQ]    = st.init_req;
    status[csf_pkg::BIT_INIT_ACK]    = (st.mode == csf_pkg::CSF_INIT);
    status[csf_pkg::BIT_SHADOW_SYNC] = st.shadow_sync;
    status[csf_pkg::BIT_CAL_INIT]    = st.cal_init;
    status[csf_pkg::BIT_SHIFT_PEND]  = st.shift_pend;
    status[csf_pkg::BIT_WAKEUP_WP]   = st.wakeup_wp;
    status[csf_pkg::BIT_ALARM_B_WP]  = st.alarm_b_wp;
    status[csf_pkg::BIT_ALARM_A_WP]  = st.alarm_a_wp;
  end

  always_comb begin
    next_st = st;
    next_st.shadow_load = 1'b0;

    // Read data valid only in the cycle after the strobe
    if (rd && (addr == csf_pkg::STATUS_OFFSET)) begin
      next_st.rdata = status;
    end else begin
      next_st.rdata = '0;
    end

    // Calibration register blocked until the new setting is taken
    if (ev.calib_done) begin
      next_st.recal = 1'b0;
    end
    if (ev.calib_write) begin
      next_st.recal = 1'b1;
    end

    // Software writes to this bit are ignored
    if (ev.shift_done) begin
      next_st.shift_pend = 1'b0;
    end
    if (ev.shift_write) begin
      next_st.shift_pend = 1'b1;
    end

    if (hit_wr) begin
      next_st.init_req = wdata[csf_pkg::BIT_INIT_REQ];
    end

    case (st.mode)
      csf_pkg::CSF_RUN: begin
        next_st.mode_cnt = '0;
        if (next_st.init_req) begin
          next_st.mode = csf_pkg::CSF_ENTERING;
        end
      end
      csf_pkg::CSF_ENTERING: begin
        // Wait for the counters to stop before granting updates
        if (!next_st.init_req) begin
          next_st.mode = csf_pkg::CSF_RUN;
        end else if (st.mode_cnt == csf_pkg::INIT_ENTRY_CYC - 2'h1) begin
          next_st.mode = csf_pkg::CSF_INIT;
        end else begin
          next_st.mode_cnt = st.mode_cnt + 2'h1;
        end
      end
      csf_pkg::CSF_INIT: begin
        // Leave in the write cycle so the acknowledge drops at once
        if (!next_st.init_req) begin
          next_st.mode = csf_pkg::CSF_RUN;
        end
      end
      default: begin
        next_st.mode = csf_pkg::CSF_RUN;
      end
    endcase
    next_st.init_mode = (next_st.mode != csf_pkg::CSF_RUN);

    // Shadow refresh; counters are read directly under bypass
    if (lv.shadow_bypass || st.mode != csf_pkg::CSF_RUN || st.shift_pend) begin
      next_st.shadow_cnt = '0;
    end else if (st.shadow_cnt == csf_pkg::SHADOW_PERIOD - 2'h1) begin
      next_st.shadow_cnt  = '0;
      next_st.shadow_load = 1'b1;
    end else begin
      next_st.shadow_cnt = st.shadow_cnt + 2'h1;
    end

    if (hit_wr && !wdata[csf_pkg::BIT_SHADOW_SYNC]) begin
      next_st.shadow_sync = 1'b0;
    end
    if (st.shadow_load) begin
      next_st.shadow_sync = 1'b1;
    end
    if (lv.shadow_bypass || st.mode != csf_pkg::CSF_RUN || st.shift_pend) begin
      next_st.shadow_sync = 1'b0;
    end

    next_st.cal_init   = lv.year_nonzero;
    next_st.wakeup_wp  = !lv.wakeup_enable;
    next_st.alarm_b_wp = !lv.alarm_b_enable;
    next_st.alarm_a_wp = !lv.alarm_a_enable;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st            <= '0;
      st.mode       <= csf_pkg::CSF_RUN;
      st.wakeup_wp  <= csf_pkg::STATUS_RESET[csf_pkg::BIT_WAKEUP_WP];
      st.alarm_b_wp <= csf_pkg::STATUS_RESET[csf_pkg::BIT_ALARM_B_WP];
      st.alarm_a_wp <= csf_pkg::STATUS_RESET[csf_pkg::BIT_ALARM_A_WP];
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rdata       = st.rdata;
  assign init_mode   = st.init_mode;
  assign shadow_load = st.shadow_load;

  sequence s_init_write;
    hit_wr && wdata[csf_pkg::BIT_INIT_REQ] && ce;
  endsequence

  chk_recal_set: assert property (@(posedge clk) disable iff (srst)
    ce && ev.calib_write |=> st.recal) else $error("recal pending not set");
  chk_ts_overflow: assert property (@(posedge clk) disable iff (srst)
    ce && ev.timestamp && fbit[3] |=> ts_ovf) else $error("overflow missed");
  chk_init_ack_after: assert property (@(posedge clk) disable iff (srst || !ce)
    s_init_write ##1 (st.init_req [*3]) |-> st.mode == csf_pkg::CSF_INIT)
    else $error("init acknowledge late");
  chk_init_exit: assert property (@(posedge clk) disable iff (srst)
    ce && hit_wr && !wdata[csf_pkg::BIT_INIT_REQ] |=> !init_mode) else $error("init not left");
  chk_shadow_sync_clr: assert property (@(posedge clk) disable iff (srst)
    ce && lv.shadow_bypass |=> !st.shadow_sync) else $error("sync kept under bypass");
  chk_shadow_period: assert property (@(posedge clk) disable iff (srst)
    ce && shadow_load |=> !shadow_load) else $error("shadow reload too often");
  chk_shift_pend: assert property (@(posedge clk) disable iff (srst)
    ce && ev.shift_write |=> st.shift_pend) else $error("shift pending not set");
  chk_sync_after_load: assert property (@(posedge clk) disable iff (srst)
    ce && st.shadow_load && !lv.shadow_bypass && st.mode == csf_pkg::CSF_RUN && !st.shift_pend
    |=> st.shadow_sync) else $error("sync flag not set");
  chk_permits: assert property (@(posedge clk) disable iff (srst)
    ce && !lv.alarm_a_enable && !lv.alarm_b_enable |=> st.alarm_a_wp && st.alarm_b_wp)
    else $error("alarm write permit wrong");

  sequence s_init_exit;
    hit_wr && !wdata[csf_pkg::BIT_INIT_REQ] && ce;
  endsequence

  // Pending flags: set and clear from the calendar core
  chk_recal_clear: assert property (@(posedge clk) disable iff (srst)
    ce && ev.calib_done && !ev.calib_write |=> !st.recal)
    else $error("recal pending not dropped");
  chk_recal_wins: assert property (@(posedge clk) disable iff (srst)
    ce && ev.calib_done && ev.calib_write |=> st.recal)
    else $error("recal pending lost");
  chk_shift_clear: assert property (@(posedge clk) disable iff (srst)
    ce && ev.shift_done && !ev.shift_write |=> !st.shift_pend)
    else $error("shift pending not dropped");
  chk_shift_wr_ign: assert property (@(posedge clk) disable iff (srst)
    ce && hit_wr && !ev.shift_write && !st.shift_pend |=> !st.shift_pend)
    else $error("shift pending set by software");

  // Event flags
  chk_tamper_two: assert property (@(posedge clk) disable iff (srst)
    ce && ev.tamper_two |=> fbit[5])
    else $error("tamper two flag not set");
  chk_tamper_one: assert property (@(posedge clk) disable iff (srst)
    ce && ev.tamper_one |=> fbit[4])
    else $error("tamper one flag not set");
  chk_stamp_flag: assert property (@(posedge clk) disable iff (srst)
    ce && ev.timestamp |=> fbit[3])
    else $error("timestamp flag not set");
  chk_stamp_clear: assert property (@(posedge clk) disable iff (srst)
    ce && hit_wr && !wdata[csf_pkg::BIT_TS] && !ev.timestamp |=> !fbit[3])
    else $error("timestamp flag not cleared");
  chk_wakeup_flag: assert property (@(posedge clk) disable iff (srst)
    ce && ev.wakeup_zero |=> fbit[2])
    else $error("wakeup flag not set");
  chk_alarm_b_flag: assert property (@(posedge clk) disable iff (srst)
    ce && ev.alarm_b_match |=> fbit[1])
    else $error("alarm b flag not set");
  chk_alarm_a_flag: assert property (@(posedge clk) disable iff (srst)
    ce && ev.alarm_a_match |=> fbit[0])
    else $error("alarm a flag not set");

  // Mode and synchronisation
  chk_init_leave: assert property (@(posedge clk) disable iff (srst)
    s_init_exit |=> st.mode == csf_pkg::CSF_RUN)
    else $error("init acknowledge held after exit");
  chk_sync_sw_clr: assert property (@(posedge clk) disable iff (srst)
    ce && hit_wr && !wdata[csf_pkg::BIT_SHADOW_SYNC] && !st.shadow_load |=> !st.shadow_sync)
    else $error("sync flag not cleared by write");
  chk_init_sync_low: assert property (@(posedge clk) disable iff (srst)
    ce && st.mode != csf_pkg::CSF_RUN |=> !st.shadow_sync)
    else $error("sync flag set in init mode");

  // Level-driven status bits
  chk_cal_init: assert property (@(posedge clk) disable iff (srst)
    ce |=> st.cal_init == $past(lv.year_nonzero))
    else $error("calendar initialized wrong");
  chk_wakeup_wp: assert property (@(posedge clk) disable iff (srst)
    ce |=> st.wakeup_wp == !$past(lv.wakeup_enable))
    else $error("wakeup write permit wrong");
  chk_alarm_a_wp: assert property (@(posedge clk) disable iff (srst)
    ce && lv.alarm_a_enable |=> !st.alarm_a_wp)
    else $error("alarm a permit kept while enabled");

endmodule : csf_status
`default_nettype wire

/* testbench/calendar_status_flags_tb.sv */
/*
  Self-checking bench for the calendar status register block.
  Assumes the csf_pkg package is compiled first; drives every port itself.
*/
`timescale 1ns/10ps
`default_nettype none
module calendar_status_flags_tb;
  // Ones on every clear-by-zero flag, zero on reserved bits
  localparam logic [31:0] KEEP = 32'h0000_7F20;
  localparam logic [31:0] NO5  = 32'hFFFF_FFDF;
  localparam logic [31:0] ALL  = 32'hFFFF_FFFF;
  localparam logic [31:0] RST  = csf_pkg::STATUS_RESET;

  logic                 clk, srst, ce, wr, rd, init_mode, shadow_load;
  logic [7:0]           addr;
  logic [31:0]          wdata, rdata, got;
  csf_pkg::csf_events_t ev;
  csf_pkg::csf_levels_t lv;
  int                   err_count, checked, cycles;

  csf_status dut_u (.clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ev(ev), .lv(lv), .init_mode(init_mode), .shadow_load(shadow_load));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard, far above the roughly 160 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report;
    $display("Summary: %0d checks, %0d mismatches", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m, input string s);
    checked++;
    if ((g & m) !== (e & m)) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk

  task automatic wr_reg(input logic [31:0] d, input logic [7:0] a = csf_pkg::STATUS_OFFSET);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a = csf_pkg::STATUS_OFFSET);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : rd_reg

  task automatic pulse(input logic [9:0] v);
    @(posedge clk);
    ev <= csf_pkg::csf_events_t'(v);
    @(posedge clk);
    ev <= '0;
  endtask : pulse

  task automatic t_reset;
    rd_reg();
    chk(got, RST, NO5, "reset value");
    @(posedge clk);
    #1 chk(rdata, 32'h0, ALL, "read data held too long");
  endtask : t_reset

  task automatic t_flags;
    int evi[6] = '{7, 6, 5, 4, 3, 2};
    int bi[6]  = '{14, 13, 11, 10, 9, 8};
    for (int i = 0; i < 6; i++) begin
      pulse(10'h001 << evi[i]);
      wr_reg(KEEP);
      rd_reg();
      chk(got, RST | (32'h1 << bi[i]), NO5, "flag set and kept");
      wr_reg(KEEP & ~(32'h1 << bi[i]));
      rd_reg();
      chk(got, RST, NO5, "flag clear by zero");
    end
  endtask : t_flags

  // Second stamp while the first is still flagged must overflow
  task automatic t_overflow;
    pulse(10'h020);
    pulse(10'h020);
    rd_reg();
    chk(got, RST | 32'h1800, NO5, "overflow set");
    wr_reg(KEEP & ~32'h0800);
    rd_reg();
    chk(got, RST | 32'h1000, NO5, "overflow survives stamp clear");
    wr_reg(KEEP & ~32'h1000);
    rd_reg();
    chk(got, RST, NO5, "overflow cleared");
  endtask : t_overflow

  task automatic t_pending;
    logic [9:0]  sv[2] = '{10'h200, 10'h002};
    logic [9:0]  dv[2] = '{10'h100, 10'h001};
    logic [31:0] pb[2] = '{32'h0001_0000, 32'h0000_0008};
    logic [31:0] mk[2] = '{NO5, ALL};
    for (int i = 0; i < 2; i++) begin
      pulse(sv[i]);
      wr_reg(KEEP);
      rd_reg();
      chk(got, RST | pb[i], mk[i], "pending set, write ignored, sync low");
      pulse(dv[i]);
      rd_reg();
      chk(got, RST, NO5, "pending dropped");
    end
  endtask : t_pending

  task automatic t_init;
    wr_reg(32'h0000_0080);
    #1 chk({31'h0, init_mode}, 32'h1, ALL, "init mode entry");
    repeat (2) @(posedge clk);
    rd_reg();
    chk(got, RST | 32'h00C0, ALL, "init acknowledged, sync low");
    wr_reg(32'h0000_0000);
    #1 chk({31'h0, init_mode}, 32'h0, ALL, "init mode exit");
    rd_reg();
    chk(got, RST, NO5, "acknowledge dropped");
  endtask : t_init

  task automatic t_shadow;
    int n;
    n = 0;
    repeat (20) begin
      @(posedge clk);
      #1 if (shadow_load === 1'b1) n++;
    end
    chk(32'(n), 32'd10, ALL, "shadow copy every two cycles");
    rd_reg();
    chk(got, RST | 32'h0020, ALL, "sync set after copy");
    @(posedge clk);
    lv.shadow_bypass <= 1'b1;
    repeat (2) @(posedge clk);
    rd_reg();
    chk(got, RST, ALL, "sync low in bypass");
    lv.shadow_bypass <= 1'b0;
  endtask : t_shadow

  // Year and enables drive the status and permit bits; writes to them do nothing
  task automatic t_levels;
    @(posedge clk);
    lv <= 5'b01111;
    wr_reg(KEEP | 32'h0000_001F);
    rd_reg();
    chk(got, 32'h0000_0010, NO5, "initialized, permits withdrawn");
    @(posedge clk);
    lv <= 5'b00000;
    rd_reg();
    chk(got, RST, NO5, "permits restored");
  endtask : t_levels

  task automatic t_unmapped;
    pulse(10'h040);
    wr_reg(32'h0, 8'h10);
    rd_reg(8'h10);
    chk(got, 32'h0, ALL, "unmapped reads zero");
    rd_reg();
    chk(got, RST | 32'h2000, NO5, "unmapped write ignored");
    wr_reg(KEEP & ~32'h2000);
  endtask : t_unmapped

  // An event while the enable is low must be lost
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    pulse(10'h080);
    @(posedge clk);
    ce <= 1'b1;
    rd_reg();
    chk(got, RST, NO5, "frozen state ignores event");
  endtask : t_freeze

  initial begin
    srst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0;
    addr = 8'h00; wdata = 32'h0; ev = '0; lv = '0;
    err_count = 0; checked = 0; cycles = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_flags();
    t_overflow();
    t_pending();
    t_init();
    t_shadow();
    t_levels();
    t_unmapped();
    t_freeze();
    final_report();
  end
endmodule : calendar_status_flags_tb
`default_nettype wire
